/* File: rtl/io_port_mode_control.sv */
// Notes on behaviour
// - Alternate function drives pad from peripheral
// - Alternate function honours open-drain or push-pull
// - Alternate function applies pull configuration
// - Alternate function samples pin every clock
// - Alternate function input read returns pin level
// - Analog mode disables output buffer
// - Analog mode forces receiver output zero
// - Analog mode forces pulls off
// - Analog mode input read returns zero
// - Oscillator off: pins follow port configuration
// - Oscillator on: port configuration ignored
// - External clock reserves only input pin
// - Standby backup pins go analog unless overridden
// - Byte, halfword, word writes update addressed bytes
// - Two-bit mode field, four encodings
// - Mode register reset depends on port
// - Drive type low sixteen bits, rest reserved
// - Slew field: x0 low, 01 medium, 11 high
// - Slew register reset depends on port
// - Input mode: no drive, receiver, pulls
// - Open-drain drives low only, never high
`timescale 1ns/1ps

module io_port_mode_control #(
	parameter int PORT_INDEX = 0,
	parameter logic [15:0] FAST_IN_MASK = 16'h0001,
	parameter logic [15:0] FAST_OUT_MASK = 16'h0002,
	parameter logic [15:0] SLOW_IN_MASK = 16'h4000,
	parameter logic [15:0] SLOW_OUT_MASK = 16'h8000,
	parameter logic [15:0] BACKUP_MASK = 16'hE000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [io_port_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [io_port_pkg::PINS-1:0] out_data,
	input wire logic [2*io_port_pkg::PINS-1:0] pin_pull_config,
	input wire logic [io_port_pkg::PINS-1:0] af_data,
	input wire logic [io_port_pkg::PINS-1:0] af_tx_en,
	input wire io_port_pkg::osc_ctrl_s osc_ctrl,
	input wire logic standby,
	input wire logic [io_port_pkg::PINS-1:0] rtc_override,
	input wire logic [io_port_pkg::PINS-1:0] pad_in,
	output io_port_pkg::pad_ctrl_s [io_port_pkg::PINS-1:0] pad_ctrl,
	output logic [io_port_pkg::PINS-1:0] input_level
);

	import io_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [31:0] pin_mode_select_q;
	logic [31:0] pin_output_type_q;
	logic [31:0] pin_output_speed_q;

	logic [PINS-1:0] pad_meta_q;
	logic [PINS-1:0] pad_sync_q;
	logic [PINS-1:0] input_level_q;

	logic [PINS-1:0] osc_owned;
	logic [PINS-1:0] rx_en_comb;
	pad_ctrl_s [PINS-1:0] pad_ctrl_d;
	pad_ctrl_s [PINS-1:0] pad_ctrl_q;

	logic access_phase;
	logic write_commit;
	logic addr_mode;
	logic addr_type;
	logic addr_speed;
	logic addr_input;
	logic addr_mapped;
	logic [31:0] byte_mask;
	logic [31:0] read_mux;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// One wait state: pready rises in the second access cycle so that every
	// bus output comes straight from a flip-flop.
	assign access_phase = psel && penable;
	assign write_commit = access_phase && pready_q && pwrite && addr_mapped;

	assign addr_mode = (paddr == PIN_MODE_SELECT_OFFSET);
	assign addr_type = (paddr == PIN_OUTPUT_TYPE_OFFSET);
	assign addr_speed = (paddr == PIN_OUTPUT_SPEED_OFFSET);
	assign addr_input = (paddr == PIN_INPUT_LEVEL_OFFSET);
	assign addr_mapped = addr_mode || addr_type || addr_speed || addr_input;

	// Lane strobes expand to a bit mask; narrow writes touch only their lanes
	generate
		for (genvar b = 0; b < WORD_BYTES; b++)
		begin : g_lane
			assign byte_mask[8*b +: 8] = {8{pstrb[b]}};
		end
	endgenerate

	always_comb
	begin
		read_mux = 32'h0000_0000;
		if (addr_mode)
		begin
			read_mux = pin_mode_select_q;
		end
		else if (addr_type)
		begin
			read_mux = pin_output_type_q;
		end
		else if (addr_speed)
		begin
			read_mux = pin_output_speed_q;
		end
		else if (addr_input)
		begin
			read_mux = {16'h0000, input_level_q};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q <= 1'b0;
		end
		else
		begin
			pready_q <= access_phase && !pready_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (access_phase && !pready_q)
		begin
			// Unmapped reads answer zero with an error
			prdata_q <= pwrite ? 32'h0000_0000 : read_mux;
			pslverr_q <= !addr_mapped;
		end
		else
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_mode_select_q <= mode_reset(PORT_INDEX);
		end
		else if (write_commit && addr_mode)
		begin
			pin_mode_select_q <= (pin_mode_select_q & ~byte_mask) | (pwdata & byte_mask);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_output_type_q <= DRIVE_TYPE_RESET;
		end
		else if (write_commit && addr_type)
		begin
			// Upper half is reserved and never stores
			pin_output_type_q[DRIVE_TYPE_LSB +: DRIVE_TYPE_W] <=
				(pin_output_type_q[DRIVE_TYPE_LSB +: DRIVE_TYPE_W] & ~byte_mask[DRIVE_TYPE_LSB +: DRIVE_TYPE_W])
				| (pwdata[DRIVE_TYPE_LSB +: DRIVE_TYPE_W] & byte_mask[DRIVE_TYPE_LSB +: DRIVE_TYPE_W]);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_output_speed_q <= slew_reset(PORT_INDEX);
		end
		else if (write_commit && addr_speed)
		begin
			pin_output_speed_q <= (pin_output_speed_q & ~byte_mask) | (pwdata & byte_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin input sampling

	// Pads are asynchronous to clk; the first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_meta_q <= '0;
			pad_sync_q <= '0;
		end
		else
		begin
			pad_meta_q <= pad_in;
			pad_sync_q <= pad_meta_q;
		end
	end

	// Sampled every clock; a disabled receiver reads as zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			input_level_q <= '0;
		end
		else
		begin
			input_level_q <= pad_sync_q & rx_en_comb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin ownership by the oscillators

	// In external clock mode only the input pin is taken
	assign osc_owned = ({PINS{osc_ctrl.fast_osc_enable}}
		& (FAST_IN_MASK | (FAST_OUT_MASK & {PINS{!osc_ctrl.fast_osc_bypass}})))
		| ({PINS{osc_ctrl.slow_osc_enable}}
		& (SLOW_IN_MASK | (SLOW_OUT_MASK & {PINS{!osc_ctrl.slow_osc_bypass}})));

	////////////////////////////////////////////////////////////////////////////
	// Per-pin pad control

	generate
		for (genvar i = 0; i < PINS; i++)
		begin : g_pin
			logic [1:0] mode;
			logic [1:0] pull;
			logic [1:0] slew;
			logic drive_en;
			logic drive_val;
			logic backup_analog;
			logic rtc_owned;

			assign mode = pin_mode_select_q[MODE_FIELD_W*i +: MODE_FIELD_W];
			assign pull = pin_pull_config[PULL_FIELD_W*i +: PULL_FIELD_W];
			assign slew = pin_output_speed_q[SLEW_FIELD_W*i +: SLEW_FIELD_W];
			assign rtc_owned = standby && BACKUP_MASK[i] && rtc_override[i];
			assign backup_analog = standby && BACKUP_MASK[i] && !rtc_override[i];

			always_comb
			begin
				pad_ctrl_d[i] = '0;
				drive_en = 1'b0;
				drive_val = 1'b0;
				// Normalise slew so the pad sees only three codes
				if (!slew[0])
				begin
					pad_ctrl_d[i].slew = SLEW_LOW;
				end
				else if (slew[1])
				begin
					pad_ctrl_d[i].slew = SLEW_HIGH;
				end
				else
				begin
					pad_ctrl_d[i].slew = SLEW_MEDIUM;
				end
				pad_ctrl_d[i].open_drain = pin_output_type_q[DRIVE_TYPE_LSB + i];
				if (osc_owned[i] || rtc_owned)
				begin
					// Another function owns the pad; port stays off it
					pad_ctrl_d[i] = '0;
					pad_ctrl_d[i].released = 1'b1;
				end
				else if (backup_analog)
				begin
					pad_ctrl_d[i].open_drain = 1'b0;
				end
				else
				begin
					unique case (mode)
						MODE_INPUT:
						begin
							pad_ctrl_d[i].rx_en = 1'b1;
						end
						MODE_OUTPUT:
						begin
							drive_en = 1'b1;
							drive_val = out_data[i];
							pad_ctrl_d[i].rx_en = 1'b1;
						end
						MODE_ALT_FUNC:
						begin
							drive_en = af_tx_en[i];
							drive_val = af_data[i];
							pad_ctrl_d[i].rx_en = 1'b1;
						end
						MODE_ANALOG:
						begin
							pad_ctrl_d[i].rx_en = 1'b0;
						end
					endcase
					// Pulls off in analog mode whatever the field holds
					if (mode != MODE_ANALOG)
					begin
						pad_ctrl_d[i].pull_up = (pull == PULL_UP);
						pad_ctrl_d[i].pull_down = (pull == PULL_DOWN);
					end
					if (pin_output_type_q[DRIVE_TYPE_LSB + i] == DRIVE_OPEN_DRAIN)
					begin
						// Sink only: a one floats the pin
						pad_ctrl_d[i].oe = drive_en && !drive_val;
						pad_ctrl_d[i].out = 1'b0;
					end
					else
					begin
						pad_ctrl_d[i].oe = drive_en;
						pad_ctrl_d[i].out = drive_val;
					end
				end
			end

			assign rx_en_comb[i] = pad_ctrl_d[i].rx_en;
		end
	endgenerate

	// Registered so pads see one clean edge per change
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_ctrl_q <= '0;
		end
		else
		begin
			pad_ctrl_q <= pad_ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pad_ctrl = pad_ctrl_q;
	assign input_level = input_level_q;

endmodule : io_port_mode_control

/* File: rtl/io_port_pkg.sv */
package io_port_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Geometry

	localparam int PINS = 16;
	localparam int APB_ADDR_W = 12;
	localparam int WORD_BYTES = 4;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets

	localparam logic [APB_ADDR_W-1:0] PIN_MODE_SELECT_OFFSET = 12'h000;
	localparam logic [APB_ADDR_W-1:0] PIN_OUTPUT_TYPE_OFFSET = 12'h004;
	localparam logic [APB_ADDR_W-1:0] PIN_OUTPUT_SPEED_OFFSET = 12'h008;
	localparam logic [APB_ADDR_W-1:0] PIN_INPUT_LEVEL_OFFSET = 12'h010;

	////////////////////////////////////////////////////////////////////////////
	// Field layout

	localparam int MODE_FIELD_W = 2;
	localparam int SLEW_FIELD_W = 2;
	localparam int PULL_FIELD_W = 2;
	localparam int DRIVE_TYPE_LSB = 0;
	localparam int DRIVE_TYPE_W = 16;

	// Mode field codes
	localparam logic [1:0] MODE_INPUT = 2'h0;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam logic [1:0] MODE_ALT_FUNC = 2'h2;
	localparam logic [1:0] MODE_ANALOG = 2'h3;

	// Drive type bit
	localparam logic DRIVE_PUSH_PULL = 1'b0;
	localparam logic DRIVE_OPEN_DRAIN = 1'b1;

	// Slew field codes as presented to the pad; any code with low bit 0 is low
	localparam logic [1:0] SLEW_LOW = 2'h0;
	localparam logic [1:0] SLEW_MEDIUM = 2'h1;
	localparam logic [1:0] SLEW_HIGH = 2'h3;

	// Pull field codes; 2'h3 is reserved and applies no pull
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_UP = 2'h1;
	localparam logic [1:0] PULL_DOWN = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Reset values; mode and slew per port index, drive type shared

	localparam logic [31:0] MODE_RESET_PORT0 = 32'hA800_0000;
	localparam logic [31:0] MODE_RESET_PORT1 = 32'h0000_0280;
	localparam logic [31:0] MODE_RESET_OTHER = 32'h0000_0000;
	localparam logic [31:0] DRIVE_TYPE_RESET = 32'h0000_0000;
	localparam logic [31:0] SLEW_RESET_PORT0 = 32'hC000_0000;
	localparam logic [31:0] SLEW_RESET_PORT1 = 32'h0000_00C0;
	localparam logic [31:0] SLEW_RESET_OTHER = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Carriers

	// Per-pin pad control bundle
	typedef struct packed {
		logic oe;
		logic out;
		logic open_drain;
		logic pull_up;
		logic pull_down;
		logic rx_en;
		logic [1:0] slew;
		logic released;
	} pad_ctrl_s;

	// Oscillator pin ownership request
	typedef struct packed {
		logic fast_osc_enable;
		logic fast_osc_bypass;
		logic slow_osc_enable;
		logic slow_osc_bypass;
	} osc_ctrl_s;

	////////////////////////////////////////////////////////////////////////////
	// Reset pickers

	function automatic logic [31:0] mode_reset(input int port_index);
		return (port_index == 0) ? MODE_RESET_PORT0 : (port_index == 1) ? MODE_RESET_PORT1 : MODE_RESET_OTHER;
	endfunction : mode_reset

	function automatic logic [31:0] slew_reset(input int port_index);
		return (port_index == 0) ? SLEW_RESET_PORT0 : (port_index == 1) ? SLEW_RESET_PORT1 : SLEW_RESET_OTHER;
	endfunction : slew_reset

endpackage : io_port_pkg

/* File: verif/io_port_mode_control_checker.sv */
`timescale 1ns/1ps

module io_port_mode_control_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire io_port_pkg::osc_ctrl_s osc_ctrl,
	input wire logic standby,
	input wire logic [io_port_pkg::PINS-1:0] rtc_override,
	input wire io_port_pkg::pad_ctrl_s [io_port_pkg::PINS-1:0] pad_ctrl,
	input wire logic [io_port_pkg::PINS-1:0] input_level
);
	import io_port_pkg::*;
	logic [PINS-1:0] rx_vec;
	logic [PINS-1:0] od_hi;
	logic [PINS-1:0] rel_bad;
	always_comb
	begin
		for (int i = 0; i < PINS; i++)
		begin
			rx_vec[i] = pad_ctrl[i].rx_en;
			od_hi[i] = pad_ctrl[i].open_drain & pad_ctrl[i].out;
			rel_bad[i] = pad_ctrl[i].released & (pad_ctrl[i].oe | pad_ctrl[i].pull_up | pad_ctrl[i].pull_down);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero while idle");
	a_od_never_high: assert property (od_hi == '0)
		else $error("open-drain pad drives high");
	a_released_quiet: assert property (rel_bad == '0)
		else $error("released pin still driven or pulled");
	a_rx_masks_input: assert property ((input_level & ~rx_vec) == '0)
		else $error("input level set while receiver off");
	a_fast_osc_pin: assert property ($past(osc_ctrl.fast_osc_enable) && osc_ctrl.fast_osc_enable |-> pad_ctrl[0].released)
		else $error("fast oscillator input pin not released");
	a_backup_analog: assert property (standby && $past(standby) && !$past(rtc_override[13]) |-> pad_ctrl[13] == '0)
		else $error("backup pin not analog in standby");
endmodule : io_port_mode_control_checker

bind io_port_mode_control io_port_mode_control_checker CHK (.clk, .rst_n, .psel, .penable, .prdata, .pready,
	.pslverr, .osc_ctrl, .standby, .rtc_override, .pad_ctrl, .input_level);

/* File: verif/pad_model.sv */
`timescale 1ns/1ps

module pad_model (
	input wire logic clk,
	input wire io_port_pkg::pad_ctrl_s [io_port_pkg::PINS-1:0] pad_ctrl,
	output logic [io_port_pkg::PINS-1:0] pad_in
);
	import io_port_pkg::*;
	// Floating pins wander so an unmapped level never looks stable
	logic [PINS-1:0] flt_q = '0;
	always_ff @(posedge clk)
	begin
		flt_q <= ~flt_q;
	end
	always_comb
	begin
		for (int i = 0; i < PINS; i++)
		begin
			pad_in[i] = pad_ctrl[i].oe ? pad_ctrl[i].out : pad_ctrl[i].pull_up ? 1'h1 : pad_ctrl[i].pull_down ? 1'h0 : flt_q[i];
		end
	end
endmodule : pad_model

/* File: verif/io_port_mode_control_tb_top.sv */
`timescale 1ns/1ps

module io_port_mode_control_tb_top;
	import io_port_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, standby, err;
	logic [APB_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [PINS-1:0] out_data, af_data, af_tx_en, rtc_override, pad_in, input_level;
	logic [2*PINS-1:0] pin_pull_config;
	osc_ctrl_s osc_ctrl;
	pad_ctrl_s [PINS-1:0] pad_ctrl;
	int fails = 0;
	int n_tests = 0;
	logic [1:0] sl;
	io_port_mode_control DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .out_data, .pin_pull_config, .af_data, .af_tx_en, .osc_ctrl, .standby, .rtc_override, .pad_in,
		.pad_ctrl, .input_level);
	pad_model PADS (.clk, .pad_ctrl, .pad_in);
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("checks=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
		begin
			fails++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'h1, a, d, s);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
		apb(1'h0, a, 32'h0, 4'h0);
		chk(rd & m, e);
	endtask : rdc
	// Waits past the register and sync stages before looking
	// Looks mid-cycle, returns on a rising edge so callers drive on the edge
	task automatic pc(input int i, input logic [8:0] e);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(32'(pad_ctrl[i]), 32'(e));
		@(posedge clk);
	endtask : pc
	////////////////////////////////////////
	initial
	begin
		rst_n = 1'h0;
		{psel, penable, pwrite, standby} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		{out_data, af_data, af_tx_en, rtc_override} = 64'h0;
		pin_pull_config = 32'h0;
		osc_ctrl = 4'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rdc(12'h000, 32'hA800_0000);
		rdc(12'h008, 32'hC000_0000);
		rdc(12'h004, 32'h0);
		pc(0, 9'h008);
		wr(12'h004, 32'hFFFF_FFFF, 4'hF);
		rdc(12'h004, 32'h0000_FFFF);
		wr(12'h004, 32'h0000_0018, 4'hF);
		wr(12'h000, 32'hFFFF_0E50, 4'h3);
		wr(12'h000, 32'h00AA_0000, 4'h4);
		rdc(12'h000, 32'hA8AA_0E50);
		wr(12'h000, 32'h0, 4'h4);
		pin_pull_config <= 32'h0000_1500;
		out_data <= 16'h000C;
		af_tx_en <= 16'h0010;
		pc(2, 9'h188);
		pc(3, 9'h048);
		pc(4, 9'h168);
		pc(5, 9'h000);
		pc(6, 9'h028);
		rdc(12'h010, 32'h0044, 32'h0074);
		af_data <= 16'h0010;
		pc(4, 9'h068);
		rdc(12'h010, 32'h0010, 32'h0010);
		wr(12'h004, 32'h0000_0008, 4'hF);
		pc(4, 9'h1A8);
		for (int c = 0; c < 4; c++)
		begin
			sl = c[0] ? 2'(c) : 2'h0;
			wr(12'h008, 32'hC000_0000 | 32'(c << 4), 4'hF);
			pc(2, 9'h188 | {6'h0, sl, 1'h0});
		end
		osc_ctrl <= 4'h8;
		pc(0, 9'h001);
		pc(1, 9'h001);
		osc_ctrl <= 4'hC;
		pc(1, 9'h008);
		osc_ctrl <= 4'h2;
		pc(14, 9'h001);
		osc_ctrl <= 4'h0;
		pc(0, 9'h008);
		standby <= 1'h1;
		rtc_override <= 16'h4000;
		pc(14, 9'h001);
		pc(13, 9'h000);
		// Analog keeps the stored slew code; drive, open-drain, pulls and receiver drop
		pc(15, 9'h006);
		standby <= 1'h0;
		apb(1'h0, 12'h020, 32'h0, 4'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rdc(12'h000, 32'hA800_0000);
		final_report();
	end
endmodule : io_port_mode_control_tb_top
